// ===== rtl/dvdp_delay_rom.sv
/*
 dvdp_delay_rom: registered lookup of power-on and ramp-step cycle counts.
 assumes codes are stable registers on the same clock.
*/
`timescale 1ns/10ps
module dvdp_delay_rom (
   input wire logic sys_clk, // register clock
   input wire logic resetn, // async reset, low
   input wire logic [3:0] dly_code, // power-on delay code
   input wire logic [1:0] step_code, // ramp step code
   output logic [dvdp_pkg::DVDP_CNT_W-1:0] dly_cyc_q, // delay in cycles
   output logic [dvdp_pkg::DVDP_CNT_W-1:0] step_cyc_q // step in cycles
);
   // ==========================================
   // delay table
   // reserved codes fall back to the longest delay, the safe side for pops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dly_cyc_q <= '0;
      end else if (dly_code > dvdp_pkg::DVDP_DLY_LAST) begin
         dly_cyc_q <= dvdp_pkg::DVDP_CNT_W'(dvdp_pkg::DVDP_DLY_US[dvdp_pkg::DVDP_DLY_LAST]
            * dvdp_pkg::DVDP_CYC_PER_US);
      end else begin
         dly_cyc_q <= dvdp_pkg::DVDP_CNT_W'(dvdp_pkg::DVDP_DLY_US[dly_code] * dvdp_pkg::DVDP_CYC_PER_US);
      end
   end
   // step table
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         step_cyc_q <= '0;
      end else begin
         step_cyc_q <= dvdp_pkg::DVDP_CNT_W'(dvdp_pkg::DVDP_STEP_MS[step_code] * dvdp_pkg::DVDP_MS_US
            * dvdp_pkg::DVDP_CYC_PER_US);
      end
   end
endmodule

// ===== rtl/dvdp_pkg.sv
/*
 dvdp_pkg: register indices, field positions, reset values and timing
 constants for the dac volume and driver power-up control bank.
 assumes a 50 MHz register clock and 8-bit register data.
*/
package dvdp_pkg;
   // ==========================================
   // register map
   localparam logic [6:0] DVDP_ADDR_POP = 7'h2a;
   localparam logic [6:0] DVDP_ADDR_LVOL = 7'h2b;
   localparam logic [6:0] DVDP_ADDR_RVOL = 7'h2c;
   localparam logic [6:0] DVDP_ADDR_LINK = 7'h29;
   localparam logic [7:0] DVDP_POP_RST = 8'h00;
   localparam logic [7:0] DVDP_VOL_RST = 8'h80;
   localparam logic [7:0] DVDP_LINK_RST = 8'h00;
   localparam logic [7:0] DVDP_POP_WMASK = 8'hfe;
   // ==========================================
   // field positions
   localparam int DVDP_DLY_HI = 7;
   localparam int DVDP_DLY_LO = 4;
   localparam int DVDP_STEP_HI = 3;
   localparam int DVDP_STEP_LO = 2;
   localparam int DVDP_CM_BIT = 1;
   localparam int DVDP_MUTE_BIT = 7;
   localparam int DVDP_LINK_HI = 1;
   localparam int DVDP_LINK_LO = 0;
   localparam logic [1:0] DVDP_LINK_L_FOLLOWS_R = 2'h1;
   localparam logic [1:0] DVDP_LINK_R_FOLLOWS_L = 2'h2;
   // ==========================================
   // timing
   localparam longint DVDP_CLK_HZ = 50000000;
   localparam longint DVDP_US_PER_S = 1000000;
   localparam longint DVDP_CYC_PER_US = DVDP_CLK_HZ / DVDP_US_PER_S;
   localparam longint DVDP_MS_US = 1000;
   localparam int DVDP_CNT_W = 28;
   // power-on delay per code, in microseconds
   localparam longint DVDP_DLY_US [0:11] = '{0, 10, 100, 1000, 10000, 50000,
      100000, 200000, 400000, 800000, 2000000, 4000000};
   // ramp step per code, in milliseconds
   localparam longint DVDP_STEP_MS [0:3] = '{0, 1, 2, 4};
   localparam int DVDP_NUM_STEPS = 8;
   // last defined delay code; codes above it are reserved
   localparam logic [3:0] DVDP_DLY_LAST = 4'hb;
   typedef enum logic [1:0] {
      DVDP_IDLE = 2'b00,
      DVDP_DELAY = 2'b01,
      DVDP_RAMP = 2'b11,
      DVDP_ON = 2'b10
   } dvdp_state_t;
endpackage

// ===== rtl/dvdp_top.sv
/*
 dvdp_top: pop-reduction and dac digital volume register bank with the
 driver power-up sequencer it steers.
 assumes a simple synchronous register port from the serial control
 decoder on the same clock; drv_en arrives from the power control logic.
*/
// Notes on behaviour
// - four-bit power-on delay, codes to fixed times
// - two-bit ramp step time, 0/1/2/4 ms
// - one bit picks divider or bandgap common-mode
// - left mute resets set, clear unmutes
// - left 7-bit attenuation, half dB steps
// - right mute resets set, clear unmutes
// - right 7-bit attenuation, half dB steps
// - linking field makes one channel follow other
`timescale 1ns/10ps
module dvdp_top (
   input wire logic sys_clk, // register clock, 50 MHz
   input wire logic resetn, // async reset, low
   input wire logic [6:0] reg_addr, // register index
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_rd, // read strobe, one cycle
   output logic [7:0] reg_rdata_q, // read data, one cycle after reg_rd
   input wire logic drv_en, // driver power request
   output logic drv_power_q, // driver bias on
   output logic [2:0] drv_ramp_q, // ramp level, 0 to 7
   output logic drv_ready_q, // driver fully up
   output logic cm_bandgap_q, // 1 bandgap, 0 analog_supply_rail divider
   output logic left_mute_q, // effective left mute
   output logic [6:0] left_atten_q, // effective left attenuation code
   output logic right_mute_q, // effective right mute
   output logic [6:0] right_atten_q // effective right attenuation code
);
   logic [7:0] pop_q;
   logic [7:0] lvol_q;
   logic [7:0] rvol_q;
   logic [7:0] link_q;
   logic [dvdp_pkg::DVDP_CNT_W-1:0] dly_cyc_q;
   logic [dvdp_pkg::DVDP_CNT_W-1:0] step_cyc_q;
   logic [dvdp_pkg::DVDP_CNT_W-1:0] cnt_q;
   logic [2:0] en_sync_q;
   logic en_s;
   dvdp_pkg::dvdp_state_t state_q;
   logic [1:0] link_sel;

   // ==========================================
   // register writes
   // bit 0 of the pop register is held at zero whatever the host sends
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pop_q <= dvdp_pkg::DVDP_POP_RST;
      end else if (reg_wr && reg_addr == dvdp_pkg::DVDP_ADDR_POP) begin
         pop_q <= reg_wdata & dvdp_pkg::DVDP_POP_WMASK;
      end
   end
   // left volume, reset muted at 0 dB
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lvol_q <= dvdp_pkg::DVDP_VOL_RST;
      end else if (reg_wr && reg_addr == dvdp_pkg::DVDP_ADDR_LVOL) begin
         lvol_q <= reg_wdata;
      end
   end
   // right volume, reset muted at 0 dB
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rvol_q <= dvdp_pkg::DVDP_VOL_RST;
      end else if (reg_wr && reg_addr == dvdp_pkg::DVDP_ADDR_RVOL) begin
         rvol_q <= reg_wdata;
      end
   end
   // linking field copy, only the two low bits are kept
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         link_q <= dvdp_pkg::DVDP_LINK_RST;
      end else if (reg_wr && reg_addr == dvdp_pkg::DVDP_ADDR_LINK) begin
         link_q <= {6'h00, reg_wdata[dvdp_pkg::DVDP_LINK_HI:dvdp_pkg::DVDP_LINK_LO]};
      end
   end

   // ==========================================
   // register reads
   // unmapped indices read as zero
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            dvdp_pkg::DVDP_ADDR_POP: reg_rdata_q <= pop_q;
            dvdp_pkg::DVDP_ADDR_LVOL: reg_rdata_q <= lvol_q;
            dvdp_pkg::DVDP_ADDR_RVOL: reg_rdata_q <= rvol_q;
            dvdp_pkg::DVDP_ADDR_LINK: reg_rdata_q <= link_q;
            default: reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // volume outputs with channel linking
   assign link_sel = link_q[dvdp_pkg::DVDP_LINK_HI:dvdp_pkg::DVDP_LINK_LO];
   // mute follows the linked register too, so a linked pair mutes together
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         left_mute_q <= dvdp_pkg::DVDP_VOL_RST[dvdp_pkg::DVDP_MUTE_BIT];
         left_atten_q <= dvdp_pkg::DVDP_VOL_RST[dvdp_pkg::DVDP_MUTE_BIT-1:0];
      end else if (link_sel == dvdp_pkg::DVDP_LINK_L_FOLLOWS_R) begin
         left_mute_q <= rvol_q[dvdp_pkg::DVDP_MUTE_BIT];
         left_atten_q <= rvol_q[dvdp_pkg::DVDP_MUTE_BIT-1:0];
      end else begin
         left_mute_q <= lvol_q[dvdp_pkg::DVDP_MUTE_BIT];
         left_atten_q <= lvol_q[dvdp_pkg::DVDP_MUTE_BIT-1:0];
      end
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         right_mute_q <= dvdp_pkg::DVDP_VOL_RST[dvdp_pkg::DVDP_MUTE_BIT];
         right_atten_q <= dvdp_pkg::DVDP_VOL_RST[dvdp_pkg::DVDP_MUTE_BIT-1:0];
      end else if (link_sel == dvdp_pkg::DVDP_LINK_R_FOLLOWS_L) begin
         right_mute_q <= lvol_q[dvdp_pkg::DVDP_MUTE_BIT];
         right_atten_q <= lvol_q[dvdp_pkg::DVDP_MUTE_BIT-1:0];
      end else begin
         right_mute_q <= rvol_q[dvdp_pkg::DVDP_MUTE_BIT];
         right_atten_q <= rvol_q[dvdp_pkg::DVDP_MUTE_BIT-1:0];
      end
   end
   // common-mode source select
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cm_bandgap_q <= dvdp_pkg::DVDP_POP_RST[dvdp_pkg::DVDP_CM_BIT];
      end else begin
         cm_bandgap_q <= pop_q[dvdp_pkg::DVDP_CM_BIT];
      end
   end

   // ==========================================
   // timing lookup
   dvdp_delay_rom u_rom (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .dly_code(pop_q[dvdp_pkg::DVDP_DLY_HI:dvdp_pkg::DVDP_DLY_LO]),
      .step_code(pop_q[dvdp_pkg::DVDP_STEP_HI:dvdp_pkg::DVDP_STEP_LO]),
      .dly_cyc_q(dly_cyc_q),
      .step_cyc_q(step_cyc_q)
   );

   // ==========================================
   // driver enable synchroniser
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         en_sync_q <= 3'h0;
      end else begin
         en_sync_q <= {en_sync_q[1:0], drv_en};
      end
   end
   // level changes only once stages two and three agree
   logic en_hold_q;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         en_hold_q <= 1'b0;
      end else if (en_sync_q[1] == en_sync_q[2]) begin
         en_hold_q <= en_sync_q[2];
      end
   end
   assign en_s = en_hold_q;

   // ==========================================
   // power-up sequencer: delay, then eight ramp steps
   // limits are re-read from the rom every cycle, so a rewrite mid-sequence
   // takes effect one cycle later; the host should not retime a running ramp
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= dvdp_pkg::DVDP_IDLE;
         cnt_q <= '0;
         drv_ramp_q <= 3'h0;
      end else if (!en_s) begin
         state_q <= dvdp_pkg::DVDP_IDLE;
         cnt_q <= '0;
         drv_ramp_q <= 3'h0;
      end else begin
         unique case (state_q)
            dvdp_pkg::DVDP_IDLE: begin
               state_q <= dvdp_pkg::DVDP_DELAY;
               cnt_q <= '0;
            end
            dvdp_pkg::DVDP_DELAY: begin
               if (cnt_q >= dly_cyc_q) begin
                  state_q <= dvdp_pkg::DVDP_RAMP;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            dvdp_pkg::DVDP_RAMP: begin
               if (cnt_q >= step_cyc_q) begin
                  cnt_q <= '0;
                  if (drv_ramp_q == 3'(dvdp_pkg::DVDP_NUM_STEPS - 1)) begin
                     state_q <= dvdp_pkg::DVDP_ON;
                  end else begin
                     drv_ramp_q <= drv_ramp_q + 3'h1;
                  end
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            dvdp_pkg::DVDP_ON: begin
               state_q <= dvdp_pkg::DVDP_ON;
            end
         endcase
      end
   end
   // outputs from flip-flops
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         drv_power_q <= 1'b0;
         drv_ready_q <= 1'b0;
      end else begin
         drv_power_q <= en_s && state_q != dvdp_pkg::DVDP_IDLE && state_q != dvdp_pkg::DVDP_DELAY;
         drv_ready_q <= en_s && state_q == dvdp_pkg::DVDP_ON;
      end
   end
endmodule

// ===== sim/dvdp_host.sv
/*
 dvdp_host: host model driving the register port.
 assumes sampling on the rising edge; drives on the falling edge.
*/
`timescale 1ns/10ps
module dvdp_host (
   input wire logic sys_clk, // clock
   output logic [6:0] reg_addr, // index
   output logic reg_wr, // write
   output logic [7:0] reg_wdata, // data
   output logic reg_rd // read
);
   // ==========================================
   // idle values
   initial begin
      reg_addr = 7'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // one-cycle write; data is inverted once released
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      if (a == dvdp_pkg::DVDP_ADDR_POP && d[7:4] > 4'hb) d[7:4] = 4'hb;
      if (a == dvdp_pkg::DVDP_ADDR_POP) d[0] = 1'b0;
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask
   // one-cycle read
   task automatic rd(input logic [6:0] a);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
   endtask
endmodule

// ===== sim/dvdp_properties.sv
/*
 dvdp_properties: port checker for dvdp_top.
 assumes one clock domain; bound to the top below.
*/
`timescale 1ns/10ps
module dvdp_properties (
   input wire logic sys_clk, // clock
   input wire logic resetn, // reset, low
   input wire logic [6:0] reg_addr, // index
   input wire logic reg_wr, // write
   input wire logic [7:0] reg_wdata, // data
   input wire logic drv_power_q, // bias on
   input wire logic [2:0] drv_ramp_q, // ramp
   input wire logic drv_ready_q, // up
   input wire logic cm_bandgap_q, // cm select
   input wire logic left_mute_q, // left mute
   input wire logic [6:0] left_atten_q, // left code
   input wire logic right_mute_q, // right mute
   input wire logic [6:0] right_atten_q // right code
);
   // ==========================================
   // link shadow
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [1:0] lk_q;
   // volume checks only hold while channels are independent
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) lk_q <= 2'h0;
      else if (reg_wr && reg_addr == dvdp_pkg::DVDP_ADDR_LINK) lk_q <= reg_wdata[1:0];
   end
   // ==========================================
   // properties
   a_left_vol_apply:
   assert property (reg_wr && reg_addr == dvdp_pkg::DVDP_ADDR_LVOL && lk_q == 2'h0
      |-> ##2 {left_mute_q, left_atten_q} == $past(reg_wdata, 2)) else $error("left volume wrong");
   a_right_vol_apply:
   assert property (reg_wr && reg_addr == dvdp_pkg::DVDP_ADDR_RVOL && lk_q == 2'h0
      |-> ##2 {right_mute_q, right_atten_q} == $past(reg_wdata, 2)) else $error("right volume wrong");
   a_cm_select:
   assert property (reg_wr && reg_addr == dvdp_pkg::DVDP_ADDR_POP
      |-> ##2 cm_bandgap_q == $past(reg_wdata[1], 2)) else $error("cm source wrong");
   a_ready_full:
   assert property (drv_ready_q |-> drv_power_q && drv_ramp_q == 3'h7) else $error("ready early");
   a_ramp_climb:
   assert property (drv_power_q && $changed(drv_ramp_q) && drv_ramp_q != 3'h0
      |-> drv_ramp_q == $past(drv_ramp_q) + 3'h1) else $error("ramp skipped");
   a_power_gate:
   assert property (!drv_power_q |-> drv_ramp_q == 3'h0 && !drv_ready_q) else $error("ramp unpowered");
   a_mute_at_reset:
   assert property ($rose(resetn) |-> left_mute_q && right_mute_q && left_atten_q == 7'h00
      && right_atten_q == 7'h00) else $error("reset values wrong");
   a_link_left:
   assert property (lk_q == 2'h1 && $past(lk_q, 3) == 2'h1
      |-> {left_mute_q, left_atten_q} == {right_mute_q, right_atten_q}) else $error("link wrong");
   a_link_right:
   assert property (lk_q == 2'h2 && $past(lk_q, 3) == 2'h2
      |-> {right_mute_q, right_atten_q} == {left_mute_q, left_atten_q}) else $error("right link wrong");
endmodule
bind dvdp_top dvdp_properties chk (.*);

// ===== sim/dvdp_top_tb.sv
/*
 dvdp_top_tb: self-checking bench for dvdp_top.
 assumes dvdp_host drives the register port.
*/
`timescale 1ns/10ps
module dvdp_top_tb;
   logic sys_clk, resetn, reg_wr, reg_rd, drv_en, drv_power_q, drv_ready_q, cm_bandgap_q;
   logic left_mute_q, right_mute_q, rd_p;
   logic [6:0] reg_addr, left_atten_q, right_atten_q, a;
   logic [7:0] reg_wdata, reg_rdata_q, d;
   logic [2:0] drv_ramp_q;
   logic [7:0] exp_q[$];
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   dvdp_top uut (.*);
   dvdp_host host (.*);
   // ==========================================
   // clock, watchdog, read monitor
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("Error t=%0t watchdog ran out", $time);
         report_and_stop();
      end
   end
   always @(posedge sys_clk) rd_p <= reg_rd;
   // read data is compared one cycle after the strobe
   always @(negedge sys_clk) if (rd_p && exp_q.size() > 0) chk(reg_rdata_q, exp_q.pop_front());
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rd_exp(input logic [6:0] ad, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(ad);
   endtask
   task automatic report_and_stop();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(32'h0b542338));
      resetn = 1'b0;
      drv_en = 1'b0;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) resetn = 1'b1;
      rd_exp(dvdp_pkg::DVDP_ADDR_POP, 8'h00);
      rd_exp(dvdp_pkg::DVDP_ADDR_LVOL, 8'h80);
      rd_exp(dvdp_pkg::DVDP_ADDR_RVOL, 8'h80);
      // volume extremes then random codes, both channels
      for (int i = 0; i < 8; i++) begin
         a = i[0] ? dvdp_pkg::DVDP_ADDR_RVOL : dvdp_pkg::DVDP_ADDR_LVOL;
         d = (i < 2) ? 8'h7f : (i < 4) ? 8'h00 : 8'($urandom());
         host.wr(a, d);
         rd_exp(a, d);
         @(negedge sys_clk);
         chk(i[0] ? {right_mute_q, right_atten_q} : {left_mute_q, left_atten_q}, d);
      end
      // every defined delay code, 0 to 11, with step and cm patterns
      for (int i = 0; i < 12; i++) begin
         d = {i[3:0], i[1:0], i[0], 1'b0};
         host.wr(dvdp_pkg::DVDP_ADDR_POP, d);
         rd_exp(dvdp_pkg::DVDP_ADDR_POP, d);
         @(negedge sys_clk);
         chk({7'h00, cm_bandgap_q}, {7'h00, d[1]});
      end
      host.wr(7'h30, 8'h5a);
      rd_exp(7'h30, 8'h00);
      // linking modes
      host.wr(dvdp_pkg::DVDP_ADDR_LVOL, 8'h11);
      host.wr(dvdp_pkg::DVDP_ADDR_RVOL, 8'h22);
      for (int i = 0; i < 4; i++) begin
         host.wr(dvdp_pkg::DVDP_ADDR_LINK, 8'(i));
         repeat (2) @(negedge sys_clk);
         chk({left_mute_q, left_atten_q}, (i == 1) ? 8'h22 : 8'h11);
         chk({right_mute_q, right_atten_q}, (i == 2) ? 8'h11 : 8'h22);
      end
      host.wr(dvdp_pkg::DVDP_ADDR_LINK, 8'h00);
      // power-up: delay code 1 is 500 cycles, code 0 none; step 0
      for (int k = 0; k < 2; k++) begin
         host.wr(dvdp_pkg::DVDP_ADDR_POP, k ? 8'h00 : 8'h10);
         drv_en = 1'b1;
         n = 0;
         while (drv_power_q !== 1'b1 && n < 600) begin
            @(negedge sys_clk);
            n++;
         end
         chk(8'(n >= (k ? 4 : 500) && n <= (k ? 10 : 512)), 8'h01);
         repeat (16) @(negedge sys_clk);
         chk({drv_ready_q, 4'h0, drv_ramp_q}, 8'h87);
         drv_en = 1'b0;
         repeat (8) @(negedge sys_clk);
         chk({drv_power_q, drv_ready_q, 6'h00}, 8'h00);
      end
      // reset in mid-run restores mute
      host.wr(dvdp_pkg::DVDP_ADDR_LVOL, 8'h05);
      resetn = 1'b0;
      @(negedge sys_clk) resetn = 1'b1;
      rd_exp(dvdp_pkg::DVDP_ADDR_LVOL, 8'h80);
      chk({left_mute_q, left_atten_q}, 8'h80);
      repeat (3) @(negedge sys_clk);
      report_and_stop();
   end
endmodule
